// [common/adcseq_defs.svh]
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// block base addresses, chosen by the map-select input
`define ADCSEQ_BASE_HI        24'hfff700
`define ADCSEQ_BASE_LO        24'h7ff700
`define ADCSEQ_BLOCK_MASK     24'hffff80

// word offsets inside the 32-word block (byte addresses; result formats as regions, address bits 6:5)
`define ADCSEQ_OFF_CFG        7'h00
`define ADCSEQ_OFF_TEST       7'h04
`define ADCSEQ_OFF_PORT       7'h08
`define ADCSEQ_OFF_CTL_FIRST  7'h0c
`define ADCSEQ_OFF_CTL_SECOND 7'h10
`define ADCSEQ_OFF_STATUS     7'h14
`define ADCSEQ_OFF_RES_RU     2'h1
`define ADCSEQ_OFF_RES_LU     2'h2
`define ADCSEQ_OFF_RES_LS     2'h3

// module config fields
`define ADCSEQ_CFG_STOP       0
`define ADCSEQ_CFG_FRZ_LO     1
`define ADCSEQ_CFG_RST        3'h1

// first control register fields
`define ADCSEQ_C0_PRS_LO      0
`define ADCSEQ_C0_STS_LO      5
`define ADCSEQ_C0_RES10       7
`define ADCSEQ_PRS_RST        5'h03

// second control register fields
`define ADCSEQ_C1_CH_LO       0
`define ADCSEQ_C1_EIGHT_CONVERSION_BIT        4
`define ADCSEQ_C1_MULTI_CHANNEL_BIT        5
`define ADCSEQ_C1_SCAN        6

// status register fields
`define ADCSEQ_ST_CH_LO       8
`define ADCSEQ_ST_BUSY        14
`define ADCSEQ_ST_SCF         15

// freeze responses
`define ADCSEQ_FRZ_IGNORE     2'h0
`define ADCSEQ_FRZ_FINISH     2'h2
`define ADCSEQ_FRZ_NOW        2'h3

// sample phase lengths in converter clocks (mux and buffer less one, direct base as is), then SAR bit settings
`define ADCSEQ_PH_MUX_LAST    5'h01
`define ADCSEQ_PH_BUF_LAST    5'h01
`define ADCSEQ_PH_DIR_BASE    6'h02
`define ADCSEQ_SAR_MSB        4'h9
`define ADCSEQ_SAR_LSB8       4'h2
`define ADCSEQ_SAR_TOP        10'h200

`endif

// [common/adcseq_pkg.sv]
package adcseq_pkg;

   // sequencer states, one-hot
   typedef enum logic [4:0]
   {
      ST_IDLE    = 5'b00001,
      ST_MUX     = 5'b00010,
      ST_BUF     = 5'b00100,
      ST_DIR     = 5'b01000,
      ST_RESOLVE = 5'b10000
   } adcseq_state_e;

   typedef logic [9:0] adcseq_result_t;

endpackage

// [logic/adcseq_prescaler.sv]
`timescale 1ns/1ps
`include "adcseq_defs.svh"

module adcseq_prescaler
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic [4:0] clock_prescale_field,
   input  wire logic       run,
   // converter clock
   output logic            tick,
   output logic            adc_clk
);

   logic [4:0] count_r;
   logic [4:0] limit;

   // reserved code zero behaves as code one, four clocks minimum
   assign limit = (clock_prescale_field == 5'h00) ? 5'h01 : clock_prescale_field;

   // first stage: modulus counter, divides by limit plus one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= 5'h00;
      else if (!run)
         count_r <= 5'h00;
      else if (count_r == limit)
         count_r <= 5'h00;
      else
         count_r <= count_r + 5'h01;
   end

   // second stage: divide by two, tick marks each full period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adc_clk <= 1'b0;
         tick    <= 1'b0;
      end
      else if (!run)
      begin
         adc_clk <= 1'b0; // gated off
         tick    <= 1'b0;
      end
      else
      begin
         if (count_r == limit)
            adc_clk <= ~adc_clk;
         tick <= (count_r == limit) && adc_clk;
      end
   end

endmodule // adcseq_prescaler

// [logic/adcseq_top.sv]
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "adcseq_defs.svh"

// What this block does
// - decode 32 words: control, port, results
// - base address picked by map-select bit
// - buffered registers take writes at once
// - bus slave terminating its own cycles
// - results readable in three data formats
// - stop gates converter clock, registers stay
// - setting stop aborts a running conversion
// - reset sets stop; software clears it
// - freeze response field selects freeze behaviour
// - frozen: clock and sequencing stop, registers valid
// - unfreeze resumes at the next step
// - channel field selects inputs or references
// - sample period: mux, buffer, direct phases
// - resolve one bit per step, MSB first
// - conversion end copies SAR to result
// - first control write aborts and halts
// - second control write restarts a sequence
// - status shows sequence, channel, completion
// - five-bit modulus prescaler then divide by two
// - prescale resets to three, divide by eight
// - at least four bus clocks per converter clock
// - sample time field gives 2,4,8,16 clocks
// - control writes clear sequence and conversion flags
// - mode number is scan, multi, eight bits
module adcseq_top
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [23:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // system
   input  wire logic        map_select_bit,
   input  wire logic        freeze,
   // analog front end
   input  wire logic [7:0]  external_analog_inputs,
   input  wire logic        comp_above,
   output logic      [3:0]  mux_select,
   output logic             sample_connect,
   output logic             buffer_charge,
   output logic             direct_connect,
   output logic      [9:0]  dac_code,
   output logic             adc_clk,
   output logic             frozen
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   adcseq_pkg::adcseq_state_e  state_r;
   adcseq_pkg::adcseq_result_t result_r [8];
   logic [4:0]  st_bits;
   logic [2:0]  cfg_r;
   logic [15:0] test_r;
   logic [7:0]  ctl0_r;
   logic [6:0]  ctl1_r;
   logic [7:0]  ccf_r;
   logic        scf_r;
   logic [2:0]  idx_r;
   logic [4:0]  cnt_r;
   logic [3:0]  bit_r;
   logic [9:0]  sar_r;
   logic [3:0]  chan_r;
   logic        tick;
   logic        run;
   logic        in_block;
   logic [6:0]  off;
   logic        wr_en;
   logic        rd_en;
   logic        wr_cfg;
   logic        wr_c0;
   logic        wr_c1;
   logic        stop_rise;
   logic        abort;
   logic        last_bit;
   logic        conv_done;
   logic        last_conv;
   logic [2:0]  mode;
   logic [1:0]  frz;
   logic [9:0]  sar_nxt;
   logic [9:0]  sel_res;
   logic [31:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   // block base follows the map-select input
   assign in_block = (paddr & `ADCSEQ_BLOCK_MASK)
                     == (map_select_bit ? `ADCSEQ_BASE_HI : `ADCSEQ_BASE_LO);
   assign off      = paddr[6:0]; // 32 words
   assign rd_en    = psel && penable && !pready;
   assign wr_en    = psel && penable && pready && pwrite && in_block;
   assign wr_cfg   = wr_en && (off[6:2] == `ADCSEQ_OFF_CFG >> 2);
   assign wr_c0    = wr_en && (off[6:2] == `ADCSEQ_OFF_CTL_FIRST >> 2);
   assign wr_c1    = wr_en && (off[6:2] == `ADCSEQ_OFF_CTL_SECOND >> 2);
   assign frz      = cfg_r[`ADCSEQ_CFG_FRZ_LO +: 2];
   assign mode     = {ctl1_r[`ADCSEQ_C1_SCAN], ctl1_r[`ADCSEQ_C1_MULTI_CHANNEL_BIT],
                      ctl1_r[`ADCSEQ_C1_EIGHT_CONVERSION_BIT]};

   // stop rising while busy, or any control write, aborts
   assign stop_rise = wr_cfg && pwdata[`ADCSEQ_CFG_STOP] && (state_r != adcseq_pkg::ST_IDLE);
   assign abort     = wr_c0 || wr_c1 || stop_rise;

   // one wait state: access phase is answered on its second cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= rd_en; // slave ends every cycle itself
         pslverr <= rd_en && !in_block;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data

   // result selected by low three word bits
   assign sel_res = result_r[off[4:2]];

   // read mux, three result formats
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      case (off[6:5])
         2'h0:
         begin
            case (off)
               `ADCSEQ_OFF_CFG:        rdata_nxt = {29'h0, cfg_r};
               `ADCSEQ_OFF_TEST:       rdata_nxt = {16'h0, test_r};
               `ADCSEQ_OFF_PORT:       rdata_nxt = {24'h0, external_analog_inputs};
               `ADCSEQ_OFF_CTL_FIRST:  rdata_nxt = {24'h0, ctl0_r};
               `ADCSEQ_OFF_CTL_SECOND: rdata_nxt = {25'h0, ctl1_r};
               `ADCSEQ_OFF_STATUS:     rdata_nxt = {16'h0, scf_r,
                                                    state_r != adcseq_pkg::ST_IDLE,
                                                    2'h0, chan_r, ccf_r};
               default:                rdata_nxt = 32'h0000_0000;
            endcase
         end
         `ADCSEQ_OFF_RES_RU:
            rdata_nxt = ctl0_r[`ADCSEQ_C0_RES10] ? {22'h0, sel_res}
                                                   : {24'h0, sel_res[9:2]};
         `ADCSEQ_OFF_RES_LU:
            rdata_nxt = {16'h0, sel_res, 6'h00};
         `ADCSEQ_OFF_RES_LS:
            rdata_nxt = {16'h0, ~sel_res[9], sel_res[8:0], 6'h00};
         default:
            rdata_nxt = 32'h0000_0000;
      endcase
   end

   // read data captured on the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en && !pwrite && in_block)
         prdata <= rdata_nxt;
      else if (rd_en)
         prdata <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   // config and test take effect at once, stop set by reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_r  <= `ADCSEQ_CFG_RST;
         test_r <= 16'h0000;
      end
      else if (wr_en)
      begin
         if (off[6:2] == `ADCSEQ_OFF_CFG >> 2)
            cfg_r <= pwdata[2:0];
         if (off[6:2] == `ADCSEQ_OFF_TEST >> 2)
            test_r <= pwdata[15:0];
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl0_r <= {3'h0, `ADCSEQ_PRS_RST};
         ctl1_r <= 7'h00;
      end
      else
      begin
         if (wr_c0)
            ctl0_r <= pwdata[7:0];
         if (wr_c1)
            ctl1_r <= pwdata[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clocking and freeze

   // freeze now, or at a conversion boundary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         frozen <= 1'b0;
      else if (!freeze || frz == `ADCSEQ_FRZ_IGNORE || frz == 2'h1)
         frozen <= 1'b0;
      else if (frz == `ADCSEQ_FRZ_NOW)
         frozen <= 1'b1;
      else
         frozen <= frozen || conv_done || (state_r == adcseq_pkg::ST_IDLE);
   end

   // an abort also restarts the prescaler, so a new sequence starts on a fixed phase
   assign run = !cfg_r[`ADCSEQ_CFG_STOP] && !frozen && !abort;

   adcseq_prescaler u_prescaler
   (
      .pclk    (pclk),
      .presetn (presetn),
      .clock_prescale_field     (ctl0_r[`ADCSEQ_C0_PRS_LO +: 5]),
      .run     (run),
      .tick    (tick),
      .adc_clk (adc_clk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   assign last_bit  = bit_r == (ctl0_r[`ADCSEQ_C0_RES10] ? 4'h0 : `ADCSEQ_SAR_LSB8);
   assign conv_done = tick && (state_r == adcseq_pkg::ST_RESOLVE) && last_bit;
   assign last_conv = idx_r == (mode[0] ? 3'h7 : 3'h3);

   // comparator decides the bit under trial
   always_comb
   begin
      sar_nxt        = sar_r;
      sar_nxt[bit_r] = comp_above;
      if (!last_bit)
         sar_nxt[bit_r - 4'h1] = 1'b1;
   end

   // state, phase counts and sar, advanced on converter clock ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= adcseq_pkg::ST_IDLE;
         cnt_r   <= 5'h00;
         bit_r   <= `ADCSEQ_SAR_MSB;
         sar_r   <= 10'h000;
         idx_r   <= 3'h0;
      end
      else if (abort)
      begin
         // second control write restarts unless stopped
         if (wr_c1 && !cfg_r[`ADCSEQ_CFG_STOP])
            state_r <= adcseq_pkg::ST_MUX;
         else
            state_r <= adcseq_pkg::ST_IDLE;
         cnt_r <= `ADCSEQ_PH_MUX_LAST;
         idx_r <= 3'h0;
         sar_r <= 10'h000;
      end
      else if (tick)
      begin
         case (state_r)
            adcseq_pkg::ST_MUX:
            begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h00)
               begin
                  state_r <= adcseq_pkg::ST_BUF;
                  cnt_r   <= `ADCSEQ_PH_BUF_LAST;
               end
            end
            adcseq_pkg::ST_BUF:
            begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h00)
               begin
                  state_r <= adcseq_pkg::ST_DIR;
                  cnt_r   <= 5'((`ADCSEQ_PH_DIR_BASE << ctl0_r[`ADCSEQ_C0_STS_LO +: 2])
                                - 6'h01);
               end
            end
            adcseq_pkg::ST_DIR:
            begin
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h00)
               begin
                  state_r <= adcseq_pkg::ST_RESOLVE;
                  bit_r   <= `ADCSEQ_SAR_MSB;
                  sar_r   <= `ADCSEQ_SAR_TOP; // msb under trial first
               end
            end
            adcseq_pkg::ST_RESOLVE:
            begin
               sar_r <= sar_nxt;
               bit_r <= bit_r - 4'h1;
               if (last_bit)
               begin
                  cnt_r <= `ADCSEQ_PH_MUX_LAST;
                  if (last_conv && !mode[2])
                     state_r <= adcseq_pkg::ST_IDLE; // index kept: status shows last channel
                  else
                  begin
                     state_r <= adcseq_pkg::ST_MUX; // next conversion, or scan repeats
                     idx_r   <= last_conv ? 3'h0 : idx_r + 3'h1;
                  end
               end
            end
            default:
               state_r <= adcseq_pkg::ST_IDLE;
         endcase
      end
   end

   // result transfer at conversion end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 8; i++)
            result_r[i] <= 10'h000;
      end
      else if (conv_done && !abort)
         result_r[idx_r] <= sar_nxt;
   end

   // completion flags, cleared by either control write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ccf_r <= 8'h00;
         scf_r <= 1'b0;
      end
      else if (wr_c0 || wr_c1)
      begin
         ccf_r <= 8'h00;
         scf_r <= 1'b0;
      end
      else if (conv_done && !abort)
      begin
         ccf_r[idx_r] <= 1'b1;
         if (last_conv)
            scf_r <= 1'b1;
      end
   end

   // channel under conversion: base, or base plus index in multi mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         chan_r <= 4'h0;
      else
         chan_r <= ctl1_r[`ADCSEQ_C1_CH_LO +: 4]
                   + (mode[1] ? {1'b0, idx_r} : 4'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // front end outputs

   assign st_bits        = state_r;
   assign mux_select     = chan_r;
   assign sample_connect = st_bits[1];
   assign buffer_charge  = st_bits[2];
   assign direct_connect = st_bits[3];
   assign dac_code       = sar_r;

endmodule // adcseq_top

// [tb/adcseq_front_model.sv]
`timescale 1ns/1ps

module adcseq_front_model
(
   // converter side
   input  wire logic        pclk,
   input  wire logic [3:0]  mux_select,
   input  wire logic [9:0]  dac_code,
   input  wire logic [79:0] levels,
   // comparator
   output logic             comp_above
);
   logic [9:0] vin;
   logic       flip = 1'b0;

   // source level per channel code; undefined codes wander every cycle
   always_comb
   begin
      case (mux_select)
         4'hc: vin = 10'h3ff;
         4'hd: vin = 10'h000;
         4'he: vin = 10'h200;
         default: vin = mux_select[3] ? {10{flip}} : levels[mux_select[2:0] * 10 +: 10];
      endcase
   end

   // pattern source for reserved codes
   always @(posedge pclk)
      flip <= ~flip;

   // ideal comparator: keep the trial bit while input is at or above it
   assign comp_above = (vin >= dac_code);
endmodule // adcseq_front_model

// [tb/adcseq_monitor.sv]
`timescale 1ns/1ps
`include "adcseq_defs.svh"

module adcseq_monitor
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [23:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // system
   input wire logic        map_select_bit,
   input wire logic        freeze,
   // analog front end
   input wire logic [7:0]  external_analog_inputs,
   input wire logic        comp_above,
   input wire logic [3:0]  mux_select,
   input wire logic        sample_connect,
   input wire logic        buffer_charge,
   input wire logic        direct_connect,
   input wire logic [9:0]  dac_code,
   input wire logic        adc_clk,
   input wire logic        frozen
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic hit, wr_ok, stop_r;

   // block decode and completed in-block writes
   assign hit = (paddr & `ADCSEQ_BLOCK_MASK) ==
                (map_select_bit ? `ADCSEQ_BASE_HI : `ADCSEQ_BASE_LO);
   assign wr_ok = pready && pwrite && hit;

   // stop bit as last written by software
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         stop_r <= 1'b1;
      else if (wr_ok && paddr[6:0] == `ADCSEQ_OFF_CFG)
         stop_r <= pwdata[`ADCSEQ_CFG_STOP];

   ////////////////////////////////////////////////////////////////////////////////
   AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("no answer one cycle into access");
   AST_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside access phase");
   AST_OUT_OF_BLOCK: assert property (pready |-> pslverr == !hit)
      else $error("pslverr does not follow decode");
   AST_QUIET_DATA: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
      else $error("read data on write or error");
   AST_PHASE_EXCL: assert property ($onehot0({sample_connect, buffer_charge, direct_connect}))
      else $error("two sample phases at once");
   AST_BUF_AFTER_MUX: assert property ($rose(buffer_charge) |-> $past(sample_connect))
      else $error("buffer phase without mux phase");
   AST_CLK_HIGH: assert property ($rose(adc_clk) && !wr_ok |=> adc_clk || frozen)
      else $error("converter clock high too short");
   AST_CLK_LOW: assert property ($fell(adc_clk) |-> !adc_clk [*2])
      else $error("converter clock low too short");
   AST_FROZEN_HOLD: assert property (frozen && $past(frozen, 2) |-> !adc_clk && $stable(dac_code))
      else $error("activity while frozen");
   AST_ABORT_IDLE: assert property (wr_ok && (paddr[6:0] == `ADCSEQ_OFF_CTL_FIRST ||
      paddr[6:0] == `ADCSEQ_OFF_CFG && pwdata[0]) |=> !(sample_connect || buffer_charge || direct_connect))
      else $error("sequence not aborted");
   AST_START: assert property (wr_ok && paddr[6:0] == `ADCSEQ_OFF_CTL_SECOND && !stop_r && !frozen
      |=> sample_connect [*3])
      else $error("sequence not started");
endmodule // adcseq_monitor

// [tb/adc_digital_sequencer_tb.sv]
`timescale 1ns/1ps
`include "adcseq_defs.svh"

// counts one comparison and reports a mismatch
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module adc_digital_sequencer_tb;
   localparam logic [6:0] o_cfg = `ADCSEQ_OFF_CFG, o_c0 = `ADCSEQ_OFF_CTL_FIRST,
                          o_c1 = `ADCSEQ_OFF_CTL_SECOND, o_st = `ADCSEQ_OFF_STATUS;
   logic        pclk, presetn, psel, penable, pwrite, map_select_bit, freeze, comp_above;
   logic        pready, pslverr, sample_connect, buffer_charge, direct_connect, adc_clk;
   logic        frozen, e;
   logic [23:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  pins;
   logic [3:0]  mux_select;
   logic [9:0]  dac_code, t10;
   logic [79:0] levels;
   logic [15:0] seed = 16'h005b;
   int          bad_count = 0, tests_run = 0, n_sc = 0, n_bc = 0, n_dc = 0, n_ck = 0;

   // design and analog front end
   adcseq_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .map_select_bit, .freeze, .external_analog_inputs(pins),
      .comp_above, .mux_select, .sample_connect, .buffer_charge, .direct_connect,
      .dac_code, .adc_clk, .frozen);
   adcseq_front_model FRONT (.pclk, .mux_select, .dac_code, .levels, .comp_above);

   // system clock, 100 ns
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // cycles spent in each sample phase and with converter clock high
   always @(posedge pclk)
   begin
      n_sc <= n_sc + int'(sample_connect);
      n_bc <= n_bc + int'(buffer_charge);
      n_dc <= n_dc + int'(direct_connect);
      n_ck <= n_ck + int'(adc_clk);
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // level the ideal comparator resolves for a channel code
   function automatic logic [9:0] lv(input logic [3:0] c);
      return c == 4'hc ? 10'h3ff : c == 4'he ? 10'h200 : c[3] ? 10'h0 : levels[c[2:0] * 10 +: 10];
   endfunction

   task automatic conclude();
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one apb transfer; q and e take the answer at the pready edge
   task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 20);
      if (n >= 20)
      begin
         bad_count++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [6:0] o);
      apb(1'b0, `ADCSEQ_BASE_HI | 24'(o), 32'h0);
   endtask

   task automatic wr(input logic [6:0] o, input logic [31:0] d);
      apb(1'b1, `ADCSEQ_BASE_HI | 24'(o), d);
   endtask

   // polls status until the sequence completes, bounded
   task automatic wait_scf();
      int k;
      for (k = 0; k < 1000; k++)
      begin
         rd(o_st);
         if (q[`ADCSEQ_ST_SCF] === 1'b1)
            return;
      end
      bad_count++;
      conclude();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int i, k, m, a0, a1, a2;
      {psel, penable, pwrite, freeze, presetn} = 5'h0;
      paddr = 24'h0;
      pwdata = 32'h0;
      map_select_bit = 1'b1;
      pins = 8'h00;
      for (i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         levels[i * 10 +: 10] = seed[9:0];
      end
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, scratch, port, reserved and unmapped places
      rd(o_cfg);
      `CHK(q[2:0], `ADCSEQ_CFG_RST)
      rd(o_c0);
      `CHK(q[4:0], `ADCSEQ_PRS_RST)
      seed = lfsr(seed);
      pins <= seed[7:0];
      wr(`ADCSEQ_OFF_TEST, {16'h0, seed});
      rd(`ADCSEQ_OFF_TEST);
      `CHK(q[15:0], seed)
      rd(`ADCSEQ_OFF_PORT);
      `CHK(q[7:0], seed[7:0])
      rd(7'h18);
      `CHK(q, 32'h0)
      apb(1'b0, 24'hfff780, 32'h0);
      `CHK(e, 1'b1)
      map_select_bit <= 1'b0;
      apb(1'b0, `ADCSEQ_BASE_LO | 24'h4, 32'h0);
      `CHK({e, q[15:0]}, {1'b0, seed})
      rd(o_cfg);
      `CHK(e, 1'b1)
      map_select_bit <= 1'b1;
      // every mode, ten-bit, fastest clock
      wr(o_cfg, 32'h0);
      t10 = lv(4'h0);
      for (m = 0; m < 8; m++)
      begin
         wr(o_c0, 32'h82); // 1.67 MHz converter clock
         wr(o_c1, {25'h0, m[2:0], 4'h0});
         wait_scf();
         `CHK(q[7:0], m[0] ? 8'hff : 8'h0f)
         for (k = 0; k < (m[0] ? 8 : 4); k++)
         begin
            rd(7'h20 + 7'(4 * k));
            `CHK(q[9:0], lv(m[1] ? 4'(k) : 4'h0))
         end
         rd(7'h40);
         `CHK(q[15:0], {t10, 6'h0})
         rd(7'h60);
         `CHK(q[15:0], {t10 ^ 10'h200, 6'h0})
      end
      wr(o_c0, 32'h82);
      rd(o_st);
      `CHK({q[15:14], q[7:0]}, 10'h0)
      // references on the multiplexer
      wr(o_c1, 32'h2c);
      wait_scf();
      `CHK(q[11:8], 4'hf)
      for (k = 0; k < 3; k++)
      begin
         rd(7'h20 + 7'(4 * k));
         `CHK(q[9:0], lv(4'hc + 4'(k)))
      end
      // phase lengths for every sample time and several prescales
      for (k = 0; k < 4; k++)
      begin
         m = k == 0 ? 3 : k + 1; // prescale 2..4 keeps 1-1.67 MHz
         wr(o_c0, {24'h0, 1'b1, k[1:0], m[4:0]});
         a0 = n_sc;
         a1 = n_bc;
         a2 = n_dc;
         wr(o_c1, 32'h0);
         wait_scf();
         `CHK(n_sc - a0, 16 * (m + 1) + 1) // start cycle plus four mux phases
         `CHK(n_bc - a1, 16 * (m + 1))
         `CHK(n_dc - a2, 8 * (2 << k) * (m + 1))
      end
      // stop aborts, gates the clock, bus stays alive
      wr(o_c0, 32'h82);
      wr(o_c1, 32'h40);
      repeat (40) @(posedge pclk);
      wr(o_cfg, 32'h1);
      a0 = n_ck;
      wr(`ADCSEQ_OFF_TEST, 32'h1234);
      wr(o_c1, 32'h0);
      rd(`ADCSEQ_OFF_TEST);
      `CHK(q[15:0], 16'h1234)
      rd(o_st);
      `CHK(q[14], 1'b0)
      `CHK(n_ck - a0, 0)
      // freeze responses: ignore, finish then freeze, freeze at once
      for (k = 0; k < 3; k++)
      begin
         m = k == 0 ? 0 : k + 1;
         wr(o_cfg, {29'h0, m[1:0], 1'b0});
         wr(o_c1, 32'h1);
         repeat (30) @(posedge pclk);
         freeze <= 1'b1;
         repeat (150) @(posedge pclk);
         a0 = n_ck;
         rd(o_c1);
         `CHK(q[3:0], 4'h1)
         `CHK(frozen, m != 0)
         `CHK(n_ck == a0, m != 0)
         freeze <= 1'b0;
         wait_scf();
         rd(7'h2c);
         `CHK(q[9:0], lv(4'h1))
      end
      // second control write restarts with new parameters
      wr(o_cfg, 32'h0);
      wr(o_c1, 32'h13);
      repeat (150) @(posedge pclk);
      wr(o_c1, 32'h05);
      rd(o_st);
      `CHK(q[7:0], 8'h00)
      wait_scf();
      `CHK(q[7:0], 8'h0f)
      rd(7'h20);
      `CHK(q[9:0], lv(4'h5))
      conclude();
   end
endmodule // adc_digital_sequencer_tb

bind adcseq_top adcseq_monitor MON (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .map_select_bit, .freeze, .external_analog_inputs,
   .comp_above, .mux_select, .sample_connect, .buffer_charge, .direct_connect, .dac_code,
   .adc_clk, .frozen);
